// >>> logic/cbu_regs.svh
// constants of the conditional branch unit: field positions, widths, reset values, cycle counts
`ifndef CBU_REGS_SVH
`define CBU_REGS_SVH

// widths
`define CBU_INSTR_W 16
`define CBU_PC_W 12
`define CBU_K_W 7
`define CBU_FLAGS_W 8

// instruction fields
`define CBU_OP_HI 15
`define CBU_OP_LO 11
`define CBU_OP_BRANCH 5'h1E
`define CBU_POL_BIT 10
`define CBU_K_HI 9
`define CBU_K_LO 3
`define CBU_SEL_HI 2
`define CBU_SEL_LO 0

// polarity: branch when the selected test is 1 or 0
`define CBU_POL_SET 1'h0
`define CBU_POL_CLEAR 1'h1

// flag selector codes carried in the instruction
`define CBU_SEL_CARRY 3'h0
`define CBU_SEL_ZERO 3'h1
`define CBU_SEL_NEG 3'h2
`define CBU_SEL_OVF 3'h3
`define CBU_SEL_SIGN 3'h4
`define CBU_SEL_HALF 3'h5
`define CBU_SEL_XFER 3'h6
`define CBU_SEL_IRQ 3'h7

// status flag positions
`define CBU_FLAG_C 0
`define CBU_FLAG_Z 1
`define CBU_FLAG_N 2
`define CBU_FLAG_V 3
`define CBU_FLAG_H 5
`define CBU_FLAG_T 6

// reset values
`define CBU_PC_RESET 12'h000
`define CBU_COUNT_RESET 16'h0000
`define CBU_COUNT_W 16

// execution cycles
`define CBU_CYCLES_NOT_TAKEN 1
`define CBU_CYCLES_TAKEN 2

`endif

// >>> logic/cbu_pkg.sv
// types and arithmetic helpers of the conditional branch unit
`include "cbu_regs.svh"

package cbu_pkg;

  typedef enum logic [3:0] {
    cbu_kind_none,
    cbu_kind_carry_set,
    cbu_kind_carry_clear,
    cbu_kind_negative,
    cbu_kind_positive,
    cbu_kind_signed_ge,
    cbu_kind_signed_less,
    cbu_kind_half_set,
    cbu_kind_half_clear,
    cbu_kind_xfer_set,
    cbu_kind_xfer_clear,
    cbu_kind_ovf_set,
    cbu_kind_ovf_clear
  } cbu_kind_t;

  typedef enum logic [0:0] {
    cbu_st_exec,
    cbu_st_bubble
  } cbu_state_t;

  typedef logic [`CBU_PC_W-1:0] cbu_pc_t;

  // signed word displacement widened to the counter width
  function automatic cbu_pc_t cbu_sext_k(input logic [`CBU_K_W-1:0] k);
    cbu_sext_k = {{(`CBU_PC_W - `CBU_K_W){k[`CBU_K_W-1]}}, k};
  endfunction

  // counter addition, wrapping within the program space
  function automatic cbu_pc_t cbu_pc_add(input cbu_pc_t a, input cbu_pc_t b);
    cbu_pc_add = cbu_pc_t'(a + b);
  endfunction

  function automatic logic [`CBU_COUNT_W-1:0] cbu_inc(input logic [`CBU_COUNT_W-1:0] c);
    cbu_inc = (c == {`CBU_COUNT_W{1'b1}}) ? c : (`CBU_COUNT_W)'(c + 1'b1);
  endfunction

endpackage

// >>> logic/cbu_dec_if.sv
// carrier between the branch unit core and its condition decoder
`timescale 1ns/100ps
`include "cbu_regs.svh"

interface cbu_dec_if;
  logic [`CBU_INSTR_W-1:0] word;
  logic [`CBU_FLAGS_W-1:0] flags;
  cbu_pkg::cbu_kind_t kind;
  logic take;
  cbu_pkg::cbu_pc_t disp;

  modport core (output word, output flags, input kind, input take, input disp);
  modport dec (input word, input flags, output kind, output take, output disp);
endinterface

// >>> logic/cbu_cond.sv
// condition decoder: classifies a branch word and evaluates its flag test
`timescale 1ns/100ps
`include "cbu_regs.svh"

module cbu_cond (
  // decode channel
  cbu_dec_if.dec dec
);

  logic is_branch;
  logic pol;
  logic [2:0] sel;
  logic n_xor_v;

  assign is_branch = (dec.word[`CBU_OP_HI:`CBU_OP_LO] == `CBU_OP_BRANCH);
  assign pol = dec.word[`CBU_POL_BIT];
  assign sel = dec.word[`CBU_SEL_HI:`CBU_SEL_LO];
  // signed tests use n xor v directly, not a stored sign flag
  assign n_xor_v = dec.flags[`CBU_FLAG_N] ^ dec.flags[`CBU_FLAG_V];
  assign dec.disp = cbu_pkg::cbu_sext_k(dec.word[`CBU_K_HI:`CBU_K_LO]);

  always_comb
  begin
    dec.kind = cbu_pkg::cbu_kind_none;
    dec.take = 1'b0;
    if (is_branch)
    begin
      unique case ({pol, sel})
        {`CBU_POL_SET, `CBU_SEL_CARRY}:
        begin
          // also serves the unsigned lower branch
          dec.kind = cbu_pkg::cbu_kind_carry_set;
          dec.take = dec.flags[`CBU_FLAG_C];
        end
        {`CBU_POL_CLEAR, `CBU_SEL_CARRY}:
        begin
          // also serves the unsigned same-or-higher branch
          dec.kind = cbu_pkg::cbu_kind_carry_clear;
          dec.take = ~dec.flags[`CBU_FLAG_C];
        end
        {`CBU_POL_SET, `CBU_SEL_NEG}:
        begin
          dec.kind = cbu_pkg::cbu_kind_negative;
          dec.take = dec.flags[`CBU_FLAG_N];
        end
        {`CBU_POL_CLEAR, `CBU_SEL_NEG}:
        begin
          dec.kind = cbu_pkg::cbu_kind_positive;
          dec.take = ~dec.flags[`CBU_FLAG_N];
        end
        {`CBU_POL_SET, `CBU_SEL_SIGN}:
        begin
          dec.kind = cbu_pkg::cbu_kind_signed_less;
          dec.take = n_xor_v;
        end
        {`CBU_POL_CLEAR, `CBU_SEL_SIGN}:
        begin
          dec.kind = cbu_pkg::cbu_kind_signed_ge;
          dec.take = ~n_xor_v;
        end
        {`CBU_POL_SET, `CBU_SEL_HALF}:
        begin
          dec.kind = cbu_pkg::cbu_kind_half_set;
          dec.take = dec.flags[`CBU_FLAG_H];
        end
        {`CBU_POL_CLEAR, `CBU_SEL_HALF}:
        begin
          dec.kind = cbu_pkg::cbu_kind_half_clear;
          dec.take = ~dec.flags[`CBU_FLAG_H];
        end
        {`CBU_POL_SET, `CBU_SEL_XFER}:
        begin
          dec.kind = cbu_pkg::cbu_kind_xfer_set;
          dec.take = dec.flags[`CBU_FLAG_T];
        end
        {`CBU_POL_CLEAR, `CBU_SEL_XFER}:
        begin
          dec.kind = cbu_pkg::cbu_kind_xfer_clear;
          dec.take = ~dec.flags[`CBU_FLAG_T];
        end
        {`CBU_POL_SET, `CBU_SEL_OVF}:
        begin
          dec.kind = cbu_pkg::cbu_kind_ovf_set;
          dec.take = dec.flags[`CBU_FLAG_V];
        end
        {`CBU_POL_CLEAR, `CBU_SEL_OVF}:
        begin
          dec.kind = cbu_pkg::cbu_kind_ovf_clear;
          dec.take = ~dec.flags[`CBU_FLAG_V];
        end
        default:
        begin
          // zero and interrupt-enable tests belong to another unit
          dec.kind = cbu_pkg::cbu_kind_none;
          dec.take = 1'b0;
        end
      endcase
    end
  end

endmodule

// >>> logic/cbu_top.sv
// conditional branch unit: executes flag-conditional relative branches and owns the counter
`timescale 1ns/100ps
`include "cbu_regs.svh"

module cbu_top (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // fetch side
  input wire logic instr_valid,
  input wire logic [`CBU_INSTR_W-1:0] instr_word,
  input wire logic hold,
  // status flags of the core
  input wire logic [`CBU_FLAGS_W-1:0] status_flags,
  // counter and pipeline control
  output logic [`CBU_PC_W-1:0] program_counter_q,
  output logic instr_ready_q,
  output logic flush_q,
  output logic redirect_q,
  // completion reporting
  output logic retire_q,
  output logic branch_taken_q,
  output logic branch_not_taken_q,
  output logic other_instr_q,
  output cbu_pkg::cbu_kind_t last_kind_q,
  // statistics
  output logic [`CBU_COUNT_W-1:0] branch_count_q,
  output logic [`CBU_COUNT_W-1:0] taken_count_q
);

  cbu_dec_if dec_ch ();

  cbu_cond u_cond (
    .dec (dec_ch)
  );

  cbu_pkg::cbu_state_t state_q;
  cbu_pkg::cbu_state_t state_d;
  cbu_pkg::cbu_pc_t target;
  cbu_pkg::cbu_pc_t fall_through;
  logic accept;
  logic is_cond;
  logic take_now;
  logic skip_now;

  // the flags are only read here; the unit has no path that writes them
  assign dec_ch.word = instr_word;
  assign dec_ch.flags = status_flags;

  // an instruction is taken from fetch only in the execute state
  assign accept = (state_q == cbu_pkg::cbu_st_exec) && instr_valid && !hold;
  assign is_cond = (dec_ch.kind != cbu_pkg::cbu_kind_none);
  assign take_now = accept && is_cond && dec_ch.take;
  assign skip_now = accept && is_cond && !dec_ch.take;

  assign fall_through = cbu_pkg::cbu_pc_add(program_counter_q, cbu_pkg::cbu_pc_t'(1'b1));
  // counter of the branch itself, plus displacement, plus one
  assign target = cbu_pkg::cbu_pc_add(fall_through, dec_ch.disp);

  // state sequencing: a taken branch owns a second cycle
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      cbu_pkg::cbu_st_exec:
      begin
        if (take_now)
        begin
          state_d = cbu_pkg::cbu_st_bubble;
        end
      end
      cbu_pkg::cbu_st_bubble:
      begin
        state_d = cbu_pkg::cbu_st_exec;
      end
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      state_q <= cbu_pkg::cbu_st_exec;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // program counter
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      program_counter_q <= `CBU_PC_RESET;
    end
    else if (take_now)
    begin
      program_counter_q <= target;
    end
    else if (accept)
    begin
      // not taken branches and all other words fall through
      program_counter_q <= fall_through;
    end
  end

  // fetch handshake: no new word is taken during the second cycle
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      instr_ready_q <= 1'b1;
    end
    else
    begin
      instr_ready_q <= (state_d == cbu_pkg::cbu_st_exec);
    end
  end

  // the word fetched behind a taken branch is dropped in the bubble cycle
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      flush_q <= 1'b0;
      redirect_q <= 1'b0;
    end
    else
    begin
      flush_q <= take_now;
      redirect_q <= take_now;
    end
  end

  // completion pulses
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      retire_q <= 1'b0;
      branch_taken_q <= 1'b0;
      branch_not_taken_q <= 1'b0;
      other_instr_q <= 1'b0;
    end
    else
    begin
      // not taken retires after its single cycle, taken after the bubble
      retire_q <= skip_now || (state_q == cbu_pkg::cbu_st_bubble);
      branch_taken_q <= (state_q == cbu_pkg::cbu_st_bubble);
      branch_not_taken_q <= skip_now;
      other_instr_q <= accept && !is_cond;
    end
  end

  // kind of the most recent conditional branch
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      last_kind_q <= cbu_pkg::cbu_kind_none;
    end
    else if (accept && is_cond)
    begin
      last_kind_q <= dec_ch.kind;
    end
  end

  // saturating statistics
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      branch_count_q <= `CBU_COUNT_RESET;
      taken_count_q <= `CBU_COUNT_RESET;
    end
    else
    begin
      if (accept && is_cond)
      begin
        branch_count_q <= cbu_pkg::cbu_inc(branch_count_q);
      end
      if (take_now)
      begin
        taken_count_q <= cbu_pkg::cbu_inc(taken_count_q);
      end
    end
  end

endmodule

// >>> tb/cbu_props.sv
// concurrent checks on the ports of the conditional branch unit
`timescale 1ns/100ps
`include "cbu_regs.svh"

module cbu_props (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // fetch side
  input wire logic instr_valid,
  input wire logic [`CBU_INSTR_W-1:0] instr_word,
  input wire logic hold,
  input wire logic [`CBU_FLAGS_W-1:0] status_flags,
  // observed outputs
  input wire logic [`CBU_PC_W-1:0] program_counter_q,
  input wire logic instr_ready_q,
  input wire logic flush_q,
  input wire logic redirect_q,
  input wire logic retire_q,
  input wire logic branch_taken_q,
  input wire logic branch_not_taken_q,
  input wire logic other_instr_q
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  redirect_pulse_a: assert property (redirect_q |=> !redirect_q)
    else $error("redirect longer than one cycle");
  flush_bubble_a: assert property (redirect_q |-> flush_q && !instr_ready_q)
    else $error("taken branch without flush and bubble");
  retire_taken_a: assert property (redirect_q |=> retire_q && branch_taken_q && instr_ready_q)
    else $error("taken branch did not retire in second cycle");
  step_not_taken_a: assert property (branch_not_taken_q |-> retire_q &&
    program_counter_q == 12'($past(program_counter_q) + 12'h001))
    else $error("not taken branch did not step by one");
  carry_cond_a: assert property (instr_valid && !hold && instr_ready_q &&
    instr_word[15:11] == `CBU_OP_BRANCH && instr_word[2:0] == 3'h0
    |=> redirect_q == ($past(status_flags[0]) ^ $past(instr_word[10])))
    else $error("carry branch decision wrong");
  branch_target_a: assert property (redirect_q |-> program_counter_q ==
    12'($past(program_counter_q) + 12'h001 + {{5{$past(instr_word[9])}}, $past(instr_word[9:3])}))
    else $error("branch target wrong");
  bubble_discard_a: assert property (!instr_ready_q |=>
    $stable(program_counter_q) && !other_instr_q && !redirect_q && !branch_not_taken_q)
    else $error("word executed during bubble");
  bubble_one_a: assert property (!instr_ready_q |=> instr_ready_q)
    else $error("bubble longer than one cycle");
  pulse_pairs_a: assert property (retire_q == (branch_taken_q || branch_not_taken_q) &&
    !(branch_taken_q && branch_not_taken_q) && !(retire_q && other_instr_q) &&
    flush_q == redirect_q)
    else $error("completion pulses inconsistent");
endmodule

bind cbu_top cbu_props u_props (.clock(clock), .resetn(resetn), .instr_valid(instr_valid),
  .instr_word(instr_word), .hold(hold), .status_flags(status_flags),
  .program_counter_q(program_counter_q), .instr_ready_q(instr_ready_q), .flush_q(flush_q),
  .redirect_q(redirect_q), .retire_q(retire_q), .branch_taken_q(branch_taken_q),
  .branch_not_taken_q(branch_not_taken_q), .other_instr_q(other_instr_q));

// >>> tb/cbu_top_tb_top.sv
// self-checking bench of the conditional branch unit
`timescale 1ns/100ps
`include "cbu_regs.svh"

module cbu_top_tb_top;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic instr_valid = 1'b0;
  logic [`CBU_INSTR_W-1:0] instr_word = 16'h0000;
  logic hold = 1'b0;
  logic [`CBU_FLAGS_W-1:0] status_flags = 8'h00;
  logic [`CBU_PC_W-1:0] pc;
  logic redirect;
  logic not_taken;
  logic other;
  logic [15:0] bcount;
  logic [15:0] tcount;
  logic [31:0] rng = 32'hF19F;
  logic [11:0] pc_m = 12'h000;
  logic bubble_m = 1'b0;
  logic [15:0] nb = 16'h0000;
  logic [15:0] nt = 16'h0000;
  logic [17:0] exp_q[$];
  logic [17:0] e;
  cbu_pkg::cbu_kind_t kind;
  cbu_pkg::cbu_kind_t kind_m = cbu_pkg::cbu_kind_none;
  logic [7:0] fl[4] = '{8'h00, 8'hFF, 8'h04, 8'h08};
  int num_errors = 0;
  int checks = 0;

  always #50 clock = ~clock;

  cbu_top DUT (.clock(clock), .resetn(resetn), .instr_valid(instr_valid),
    .instr_word(instr_word), .hold(hold), .status_flags(status_flags),
    .program_counter_q(pc), .instr_ready_q(), .flush_q(), .redirect_q(redirect),
    .retire_q(), .branch_taken_q(), .branch_not_taken_q(not_taken),
    .other_instr_q(other), .last_kind_q(kind), .branch_count_q(bcount), .taken_count_q(tcount));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    xs = x ^ (x << 5);
  endfunction

  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // drives one cycle and notes what the unit must do with it
  task automatic step(input logic [15:0] w, input logic [7:0] f, input logic v, input logic h);
    logic t;
    logic hd;
    cbu_pkg::cbu_kind_t k;
    @(negedge clock);
    instr_word = w;
    status_flags = f;
    instr_valid = v;
    hold = h;
    case (w[2:0])
      3'h0: t = f[`CBU_FLAG_C];
      3'h2: t = f[`CBU_FLAG_N];
      3'h3: t = f[`CBU_FLAG_V];
      3'h4: t = f[`CBU_FLAG_N] ^ f[`CBU_FLAG_V];
      3'h5: t = f[`CBU_FLAG_H];
      3'h6: t = f[`CBU_FLAG_T];
      default: t = 1'b0;
    endcase
    // kind reported for each polarity and selector
    case ({w[10], w[2:0]})
      4'h0: k = cbu_pkg::cbu_kind_carry_set;
      4'h8: k = cbu_pkg::cbu_kind_carry_clear;
      4'h2: k = cbu_pkg::cbu_kind_negative;
      4'hA: k = cbu_pkg::cbu_kind_positive;
      4'h3: k = cbu_pkg::cbu_kind_ovf_set;
      4'hB: k = cbu_pkg::cbu_kind_ovf_clear;
      4'h4: k = cbu_pkg::cbu_kind_signed_less;
      4'hC: k = cbu_pkg::cbu_kind_signed_ge;
      4'h5: k = cbu_pkg::cbu_kind_half_set;
      4'hD: k = cbu_pkg::cbu_kind_half_clear;
      4'h6: k = cbu_pkg::cbu_kind_xfer_set;
      4'hE: k = cbu_pkg::cbu_kind_xfer_clear;
      default: k = cbu_pkg::cbu_kind_none;
    endcase
    hd = (w[15:11] == `CBU_OP_BRANCH) && (w[2:0] != 3'h1) && (w[2:0] != 3'h7);
    t = hd && (t ^ w[10]);
    if (bubble_m)
      bubble_m = 1'b0;
    else if (v && !h && resetn)
    begin
      pc_m = t ? 12'(pc_m + 12'h001 + {{5{w[9]}}, w[9:3]}) : 12'(pc_m + 12'h001);
      if (hd)
        kind_m = k;
      exp_q.push_back({kind_m, hd ? {1'b0, t} : 2'h2, pc_m});
      nb = nb + {15'h0000, hd};
      nt = nt + {15'h0000, t};
      bubble_m = t;
    end
  endtask

  always @(negedge clock)
    if (resetn && (not_taken || redirect || other))
    begin
      e = exp_q.size() > 0 ? exp_q.pop_front() : 18'h3FFFF;
      cmp({2'h0, redirect ? 2'h1 : (other ? 2'h2 : 2'h0), pc}, {2'h0, e[13:0]});
      cmp({12'h000, kind}, {12'h000, e[17:14]});
    end

  task automatic conclude();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    repeat (3) @(negedge clock);
    resetn = 1'b1;
    for (int s = 0; s < 16; s++)
      for (int f = 0; f < 4; f++)
        step({5'h1E, s[3], 7'(s * 9 + f * 37), s[2:0]}, fl[f], 1'b1, 1'b0);
    $display("test directed done");
    repeat (3000)
    begin
      rng = xs(rng);
      step(rng[31:29] == 3'h0 ? rng[15:0] : {5'h1E, rng[10:0]}, rng[23:16],
        rng[24] | rng[25], rng[26] & rng[27]);
    end
    $display("test random done");
    repeat (4) step(16'h0000, 8'h00, 1'b0, 1'b0);
    cmp(16'(exp_q.size()), 16'h0000);
    cmp(bcount, nb);
    cmp(tcount, nt);
    $display("test counts done");
    conclude();
  end
endmodule
